// >>> include/tap_pkg.sv
// Shared constants and types for the boundary-scan test port and its controller
package tap_pkg;
    localparam int          IR_W        = 3;
    localparam int          ID_W        = 32;
    localparam int          TLR_ONES    = 5;
    localparam logic [2:0]  IR_EXTEST   = 3'h0;
    localparam logic [2:0]  IR_IDCODE   = 3'h1;
    localparam logic [2:0]  IR_SAMPLE   = 3'h2;
    localparam logic [2:0]  IR_BYPASS   = 3'h7;
    localparam logic [2:0]  IR_RESET    = IR_IDCODE;
    localparam logic [1:0]  IR_CAPTURE  = 2'h1;
    localparam logic [31:0] ID_DEFAULT  = 32'h0000_0001;  // Arbitrary value
    localparam int          TCK_HALF    = 4;
    localparam logic [7:0]  CNT_RESET   = 8'h00;

    typedef enum logic [3:0] {
        ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR,
        ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
        ST_PA_IR, ST_EX2_IR, ST_UPD_IR
    } tap_state_t;

    // Next state of the sixteen-state test controller
    function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
        case (s)
            ST_TLR:    tap_next = tms ? ST_TLR    : ST_RTI;
            ST_RTI:    tap_next = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_next = tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR:  tap_next = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: tap_next = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: tap_next = tms ? ST_TLR    : ST_CAP_IR;
            ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tap_next = tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR:  tap_next = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: tap_next = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_RTI;
            default:   tap_next = ST_TLR;
        endcase
    endfunction
endpackage

// >>> include/tap_if.sv
// Four-wire test link between scan controller and test port
`timescale 1ns/100ps
interface tap_if;
    logic tck;
    logic tms;
    logic tms_oe;
    logic tdi;
    logic tdi_oe;
    logic tdo;
    logic tdo_oe;

    // Undriven inputs read as one, as the internal pull-ups do
    wire tms_pin = tms_oe ? tms : 1'b1;
    wire tdi_pin = tdi_oe ? tdi : 1'b1;

    modport dev (input tck, input tms, input tms_oe, input tdi, input tdi_oe,
                 output tdo, output tdo_oe, input tms_pin, input tdi_pin);
    modport ctl (output tck, output tms, output tms_oe, output tdi, output tdi_oe,
                 input tdo, input tdo_oe);
endinterface

// >>> src/tap_ctl.sv
// Scan controller end: generates the test clock and shifts IR or DR scans
`timescale 1ns/100ps
module tap_ctl
    import tap_pkg::*;
#(
    parameter int LEN_W = 8
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rstn,
    input  wire logic             i_ce,
    input  wire logic             i_start,
    input  wire logic             i_ir_scan,
    input  wire logic             i_reset_seq,
    input  wire logic [LEN_W-1:0] i_len,
    input  wire logic [31:0]      i_data,
    output logic                  o_busy,
    output logic                  o_done,
    output logic [31:0]           o_data,
    tap_if.ctl                    link
);
    typedef enum logic [2:0] {C_IDLE, C_RST, C_PRE, C_SHIFT, C_POST} cst_t;

    cst_t             st_q, st_d;
    logic [7:0]       div_q, div_d;
    logic             tck_q, tck_d;
    logic [LEN_W-1:0] cnt_q, cnt_d;
    logic [4:0]       tms_seq_q, tms_seq_d;
    logic [31:0]      sh_q, sh_d;
    logic [31:0]      cap_q, cap_d;
    logic             tms_q, tms_d, tdi_q, tdi_d, done_q, done_d;
    logic             tms_oe_q, tms_oe_d, tdi_oe_q, tdi_oe_d, busy_q, busy_d;
    logic             tdo_s1_q, tdo_s2_q;
    logic             fall;

    // Controller drives on the falling edge, device samples on the rising [RULE_01]
    assign fall = tck_q && (div_q == 8'(TCK_HALF - 1));

    always_comb begin
        st_d = st_q; div_d = div_q; tck_d = tck_q; cnt_d = cnt_q;
        tms_seq_d = tms_seq_q; sh_d = sh_q; cap_d = cap_q;
        tms_d = tms_q; tdi_d = tdi_q; done_d = 1'b0;
        tms_oe_d = tms_oe_q; tdi_oe_d = tdi_oe_q;
        if (st_q != C_IDLE) begin
            div_d = (div_q == 8'(TCK_HALF - 1)) ? CNT_RESET : div_q + 8'h01;
            if (div_q == 8'(TCK_HALF - 1)) tck_d = ~tck_q;
        end
        case (st_q)
            C_IDLE: if (i_start) begin
                cnt_d = i_len;
                sh_d  = i_data;
                // Clock starts low so TMS settles a half period before the first rise [RULE_01]
                tck_d = 1'b0;
                div_d = CNT_RESET;
                if (i_reset_seq) begin
                    st_d = C_RST;
                    // Released: only the pull-up supplies the ones [RULE_03]
                    tms_oe_d = 1'b0;
                    cnt_d = LEN_W'(TLR_ONES - 1);       // [RULE_08]
                end else begin
                    // From Run-Test/Idle: 1(,1),0,0 then shift
                    st_d = C_PRE;
                    tms_seq_d = i_ir_scan ? 5'h03 : 5'h01;
                    tms_d = 1'b1;
                    cnt_d = i_ir_scan ? LEN_W'(3) : LEN_W'(2);
                end
            end
            C_RST: if (fall) begin
                if (cnt_q == '0) begin
                    tms_d = 1'b0;                   // Park in Run-Test/Idle
                    tms_oe_d = 1'b1;
                    st_d = C_POST;
                    cnt_d = '0;
                end else cnt_d = cnt_q - 1'b1;
            end
            C_PRE: if (fall) begin
                if (cnt_q == '0) begin
                    st_d = C_SHIFT;
                    cnt_d = i_len - 1'b1;
                    // Ones are left to the pull-up, zeros driven [RULE_04]
                    tdi_oe_d = ~sh_q[0];
                    if (!sh_q[0]) tdi_d = 1'b0;
                    tms_d = (i_len == LEN_W'(1));
                end else begin
                    tms_seq_d = tms_seq_q >> 1;
                    tms_d = tms_seq_q[1];
                    cnt_d = cnt_q - 1'b1;
                end
            end
            C_SHIFT: if (fall) begin
                cap_d = {tdo_s2_q, cap_q[31:1]};
                sh_d  = sh_q >> 1;
                tdi_oe_d = ~sh_q[1];
                if (!sh_q[1]) tdi_d = 1'b0;
                if (tms_q) begin
                    st_d = C_POST;
                    cnt_d = LEN_W'(1);              // Exit1 -> Update -> Idle
                    tms_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                    tms_d = (cnt_q == LEN_W'(1));
                end
            end
            C_POST: if (fall) begin
                tms_d = 1'b0;
                if (cnt_q == '0) begin
                    st_d = C_IDLE;
                    done_d = 1'b1;
                end else cnt_d = cnt_q - 1'b1;
            end
            default: st_d = C_IDLE;
        endcase
        busy_d = (st_d != C_IDLE);
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q <= C_IDLE; div_q <= CNT_RESET; tck_q <= 1'b0; cnt_q <= '0;
            tms_seq_q <= 5'h00; sh_q <= 32'h0; cap_q <= 32'h0;
            tms_q <= 1'b1; tdi_q <= 1'b1; done_q <= 1'b0;
            tms_oe_q <= 1'b1; tdi_oe_q <= 1'b1; busy_q <= 1'b0;
            tdo_s1_q <= 1'b1; tdo_s2_q <= 1'b1;
        end else if (i_ce) begin
            st_q <= st_d; div_q <= div_d; tck_q <= tck_d; cnt_q <= cnt_d;
            tms_seq_q <= tms_seq_d; sh_q <= sh_d; cap_q <= cap_d;
            tms_q <= tms_d; tdi_q <= tdi_d; done_q <= done_d;
            tms_oe_q <= tms_oe_d; tdi_oe_q <= tdi_oe_d; busy_q <= busy_d;
            tdo_s1_q <= link.tdo;
            tdo_s2_q <= tdo_s1_q;
        end
    end

    assign link.tck    = tck_q;
    assign link.tms    = tms_q;
    assign link.tms_oe = tms_oe_q;
    assign link.tdi    = tdi_q;
    assign link.tdi_oe = tdi_oe_q;
    assign o_busy      = busy_q;
    assign o_done      = done_q;
    assign o_data      = cap_q;
endmodule

// >>> src/tap_port.sv
// Device end: boundary-scan test access port of the memory
`timescale 1ns/100ps
// Operation
// RULE_01: Sample on rising TCK, launch on falling
// RULE_02: TMS alone steps the controller
// RULE_03: Floating TMS reads as one
// RULE_04: Floating TDI reads as one
// RULE_05: State and instruction select scan path
// RULE_06: TDO enabled selectively, changes on falling TCK
// RULE_07: No test reset pin; TMS or power-up
// RULE_08: Five TMS highs reach Test-Logic-Reset
// RULE_09: Controller resets itself at power-up
// RULE_10: Idle after reset until TCK toggles
// RULE_11: Unused port: TDO open, inputs free
// RULE_12: Follow standard sequencing and public instructions
// RULE_13: Three-bit IR, loaded only while selected
// RULE_14: IR preset to IDCODE in reset
// RULE_15: Capture-IR loads 01 into low bits
// RULE_16: One-bit bypass register
// RULE_17: Standard sixteen-state controller
// RULE_18: TDO driven only in Shift-IR/DR
module tap_port
    import tap_pkg::*;
#(
    parameter int          BSR_W   = 8,
    parameter logic [31:0] ID_CODE = ID_DEFAULT   // Arbitrary value
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rstn,
    input  wire logic             i_ce,
    input  wire logic [BSR_W-1:0] i_pins,
    output logic [BSR_W-1:0]      o_pins,
    output logic                  o_extest,
    output logic [IR_W-1:0]       o_ir,
    tap_if.dev                    link
);
    // ==========================================================
    // Input synchronisers
    logic [1:0] tck_s_q, tms_s_q, tdi_s_q;
    logic       tck_d3_q;
    logic       rise, fall, tms, tdi;

    assign rise = tck_s_q[1] && !tck_d3_q;  // [RULE_01]
    assign fall = !tck_s_q[1] && tck_d3_q;  // [RULE_01]
    assign tms  = tms_s_q[1];               // [RULE_03]
    assign tdi  = tdi_s_q[1];               // [RULE_04]

    // ==========================================================
    // Controller and registers
    tap_state_t         st_q, st_d;
    logic [IR_W-1:0]    irs_q, irs_d, ir_q, ir_d;
    logic [ID_W-1:0]    dr_q, dr_d;
    logic [BSR_W-1:0]   bsr_q, bsr_d, upd_q, upd_d;
    logic               byp_q, byp_d;
    logic               tdo_q, tdo_d, oe_q, oe_d;
    logic               sel_out;
    logic               extest_q, extest_d;

    // Scan path choice from state and instruction [RULE_05]
    always_comb begin
        if (st_q == ST_SH_IR) sel_out = irs_q[0];
        else case (ir_q)
            IR_IDCODE:            sel_out = dr_q[0];
            IR_EXTEST, IR_SAMPLE: sel_out = bsr_q[0];
            default:              sel_out = byp_q;   // [RULE_16]
        endcase
    end

    always_comb begin
        st_d = st_q; irs_d = irs_q; ir_d = ir_q; dr_d = dr_q; bsr_d = bsr_q;
        upd_d = upd_q; byp_d = byp_q; tdo_d = tdo_q; oe_d = oe_q;
        // Nothing moves until TCK toggles, memory side unaffected [RULE_10]
        if (rise) begin
            st_d = tap_next(st_q, tms);                      // [RULE_02] [RULE_17] [RULE_12]
            case (st_q)
                ST_TLR:    ir_d = IR_RESET;                  // [RULE_14]
                ST_CAP_IR: irs_d = {irs_q[IR_W-1:2], IR_CAPTURE};  // [RULE_15]
                ST_SH_IR:  irs_d = {tdi, irs_q[IR_W-1:1]};   // [RULE_13]
                ST_UPD_IR: ir_d = irs_q;
                ST_CAP_DR: begin
                    dr_d  = ID_CODE;
                    bsr_d = i_pins;
                    byp_d = 1'b0;
                end
                ST_SH_DR: case (ir_q)
                    IR_IDCODE:            dr_d = {tdi, dr_q[ID_W-1:1]};
                    IR_EXTEST, IR_SAMPLE: bsr_d = {tdi, bsr_q[BSR_W-1:1]};
                    default:              byp_d = tdi;       // [RULE_16]
                endcase
                ST_UPD_DR: if (ir_q == IR_EXTEST || ir_q == IR_SAMPLE) upd_d = bsr_q;
                default: ;
            endcase
            // Five ones from any state land here [RULE_08]
            if (tap_next(st_q, tms) == ST_TLR) ir_d = IR_RESET;  // [RULE_14]
        end
        if (fall) begin
            oe_d  = (st_q == ST_SH_IR) || (st_q == ST_SH_DR);  // [RULE_18] [RULE_06]
            tdo_d = sel_out;                                   // [RULE_06]
        end
        extest_d = (ir_d == IR_EXTEST);
    end

    // No test reset pin: only power-up reset and the TMS path [RULE_07] [RULE_09]
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            tck_s_q <= 2'h0; tms_s_q <= 2'h3; tdi_s_q <= 2'h3; tck_d3_q <= 1'b0;
            st_q <= ST_TLR; irs_q <= IR_RESET; ir_q <= IR_RESET;
            dr_q <= '0; bsr_q <= '0; upd_q <= '0; byp_q <= 1'b0;
            tdo_q <= 1'b1; oe_q <= 1'b0;
            extest_q <= 1'b0;
        end else if (i_ce) begin
            // Only the second stage feeds logic; tck_d3_q is the edge finder's memory
            tck_s_q  <= {tck_s_q[0], link.tck};
            tms_s_q  <= {tms_s_q[0], link.tms_pin};
            tdi_s_q  <= {tdi_s_q[0], link.tdi_pin};
            tck_d3_q <= tck_s_q[1];
            st_q <= st_d; irs_q <= irs_d; ir_q <= ir_d; dr_q <= dr_d;
            bsr_q <= bsr_d; upd_q <= upd_d; byp_q <= byp_d;
            tdo_q <= tdo_d; oe_q <= oe_d;
            extest_q <= extest_d;
        end
    end

    assign link.tdo    = tdo_q;
    assign link.tdo_oe = oe_q;
    assign o_pins      = upd_q;
    assign o_extest    = extest_q;
    assign o_ir        = ir_q;
endmodule

// >>> test/tap_link_sva.sv
// Wire-level checks on the test link between scan controller and port
`timescale 1ns/100ps
module tap_link_sva (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tms_oe,
    input wire logic tdi,
    input wire logic tdi_oe,
    input wire logic tdo,
    input wire logic tdo_oe
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    logic       tck_q, tck_d, one_q, one_d;
    logic [3:0] still_q, still_d;
    wire        rise    = tck && !tck_q;
    // Undriven select reads as one
    wire        tms_rd  = tms_oe ? tms : 1'b1;
    // ================================
    // Helper state
    always_comb begin
        tck_d   = tck;
        one_d   = rise ? tms_rd : one_q;
        still_d = (tck != tck_q) ? 4'h0 : ((still_q == 4'hF) ? 4'hF : still_q + 4'h1);
    end
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            tck_q   <= 1'b0;
            one_q   <= 1'b1;
            still_q <= 4'h0;
        end else begin
            tck_q   <= tck_d;
            one_q   <= one_d;
            still_q <= still_d;
        end
    end
    // ================================
    // Assertions
    sequence half_high;
        tck [*4] ##1 !tck;
    endsequence
    sequence half_low;
        (!tck) [*4];
    endsequence
    a_tdo_on_low: assert property ($changed(tdo) |-> !tck)
        else $error("tdo moved while test clock high");
    a_oe_on_low: assert property ($changed(tdo_oe) |-> !tck)
        else $error("tdo enable moved while test clock high");
    a_drive_on_low: assert property ($changed({tms, tms_oe, tdi, tdi_oe}) |-> !tck)
        else $error("controller drive moved while test clock high");
    a_tck_high_half: assert property ($rose(tck) |-> half_high)
        else $error("test clock high phase wrong");
    a_tck_low_half: assert property ($fell(tck) |-> half_low)
        else $error("test clock low phase too short");
    a_idle_quiet: assert property (still_q > 4'h4 |-> $stable(tdo) && $stable(tdo_oe))
        else $error("tdo moved with test clock still");
    a_exit_no_drive: assert property (rise && one_q |-> !tdo_oe)
        else $error("tdo driven outside shift");
    a_reset_quiet: assert property ($rose(i_rstn) |-> !tdo_oe && tdo)
        else $error("tdo not released after reset");
endmodule

// >>> test/boundary_scan_tap_port_bench.sv
// Self-checking bench: scan controller and test port joined over the link
`timescale 1ns/100ps
module boundary_scan_tap_port_bench;
    import tap_pkg::*;
    logic        i_mclk, o_busy, o_done, o_extest;
    logic        i_rstn = 1'b0, i_start = 1'b0, i_ir_scan = 1'b0, i_reset_seq = 1'b0;
    logic [7:0]  i_len  = 8'h01, i_pins = 8'h00, o_pins, p;
    logic [31:0] i_data = 32'h0, o_data, d;
    logic [2:0]  o_ir;
    logic [2:0]  codes [5] = '{IR_BYPASS, 3'h3, 3'h4, 3'h5, 3'h6};
    int          fail_count = 0, samples_checked = 0, n;
    tap_if link();
    tap_ctl i_tap_ctl (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(1'b1), .i_start(i_start),
        .i_ir_scan(i_ir_scan), .i_reset_seq(i_reset_seq), .i_len(i_len), .i_data(i_data),
        .o_busy(o_busy), .o_done(o_done), .o_data(o_data), .link(link));
    tap_port i_tap_port (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(1'b1), .i_pins(i_pins),
        .o_pins(o_pins), .o_extest(o_extest), .o_ir(o_ir), .link(link));
    tap_link_sva i_link_sva (.i_mclk(i_mclk), .i_rstn(i_rstn), .tck(link.tck), .tms(link.tms),
        .tms_oe(link.tms_oe), .tdi(link.tdi), .tdi_oe(link.tdi_oe), .tdo(link.tdo),
        .tdo_oe(link.tdo_oe));
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    // ================================
    // Tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task scan(input logic ir, input logic rs, input int len, input logic [31:0] data);
        int k;
        @(posedge i_mclk);
        i_start     <= 1'b1;
        i_ir_scan   <= ir;
        i_reset_seq <= rs;
        i_len       <= 8'(len);
        i_data      <= data;
        @(posedge i_mclk);
        i_start <= 1'b0;
        @(posedge i_mclk);
        chk(32'(o_busy), 32'h1);
        k = 0;
        // Bounded wait so a stuck scan cannot hang the run
        while (o_done !== 1'b1 && k < 2000) begin
            @(posedge i_mclk);
            k++;
        end
        chk(32'(k < 2000), 32'h1);
        chk(32'(o_busy), 32'h0);
    endtask
    // Bypass adds one captured zero ahead of the data
    function automatic logic [31:0] byp_exp(input logic [31:0] v, input int len);
        return {v[30:0], 1'b0} << (32 - len);
    endfunction
    task final_report;
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        fail_count++;
        final_report;
    end
    // ================================
    // Main sequence
    initial begin
        void'($urandom(32'h4371));
        repeat (10) @(posedge i_mclk);
        i_rstn <= 1'b1;
        scan(1'b0, 1'b1, 1, 32'h0);
        chk({29'h0, o_ir}, {29'h0, IR_IDCODE});
        d = $urandom;
        scan(1'b0, 1'b0, 32, d);
        chk(o_data, ID_DEFAULT);
        $display("test idcode done");
        for (int i = 0; i < 5; i++) begin
            scan(1'b1, 1'b0, 3, {29'h0, codes[i]});
            chk({30'h0, o_data[30:29]}, {30'h0, IR_CAPTURE});
            chk({29'h0, o_ir}, {29'h0, codes[i]});
            n = (i == 0) ? 32 : (i == 1) ? 2 : 2 + int'($urandom % 31);
            d = $urandom;
            scan(1'b0, 1'b0, n, d);
            // Bits below the scan length still hold the previous capture
            chk(o_data & (32'hFFFF_FFFF << (32 - n)), byp_exp(d, n));
        end
        $display("test bypass done");
        p = 8'($urandom);
        i_pins <= p;
        scan(1'b1, 1'b0, 3, {29'h0, IR_SAMPLE});
        scan(1'b0, 1'b0, 8, 32'h0);
        chk({24'h0, o_data[31:24]}, {24'h0, p});
        chk({31'h0, o_extest}, 32'h0);
        scan(1'b1, 1'b0, 3, {29'h0, IR_EXTEST});
        chk({31'h0, o_extest}, 32'h1);
        d = $urandom;
        scan(1'b0, 1'b0, 8, d);
        chk({24'h0, o_data[31:24]}, {24'h0, p});
        chk({24'h0, o_pins}, {24'h0, d[7:0]});
        $display("test boundary done");
        scan(1'b1, 1'b0, 3, {29'h0, IR_BYPASS});
        scan(1'b0, 1'b1, 1, 32'h0);
        chk({29'h0, o_ir}, {29'h0, IR_IDCODE});
        chk({31'h0, o_extest}, 32'h0);
        $display("test reset done");
        final_report;
    end
endmodule
